/* bench/lsrd_link_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
module lsrd_link_assertions
(
    input wire logic       clk_sys,
    input wire logic       rst_n,
    input wire logic       hdr_valid,
    input wire logic [7:0] hdr_pid,
    input wire logic       mdat_valid,
    input wire logic       mdat_ready,
    input wire logic [7:0] mdat_byte,
    input wire logic       mdat_last,
    input wire logic       sdat_valid,
    input wire logic       sdat_ready,
    input wire logic [7:0] sdat_byte,
    input wire logic       sdat_last
);
    typedef struct packed
    {
        logic [3:0] len;
        logic [3:0] mcnt;
        logic [3:0] scnt;
        logic [7:0] msum;
        logic [7:0] ssum;
    } lsrd_chk_type;
    lsrd_chk_type st_q;
    lsrd_chk_type st_d;
    logic         mbeat;
    logic         sbeat;
    assign mbeat = mdat_valid && mdat_ready;
    assign sbeat = sdat_valid && sdat_ready;

    function automatic logic [7:0] add_c(input logic [7:0] a, b);
        logic [8:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[7:0] + {7'h00, s[8]};
    endfunction

    // ------------------------------------------------------------
    // Per-frame counts and sums
    // ------------------------------------------------------------
    always_comb
    begin
        st_d = st_q;
        if (hdr_valid)
        begin
            st_d = '0;
            st_d.len = hdr_pid[5] ? (hdr_pid[4] ? 4'h8 : 4'h4) : 4'h2;
        end
        if (mbeat)
        begin
            st_d.mcnt = mdat_last ? 4'h0 : st_q.mcnt + 4'h1;
            st_d.msum = mdat_last ? 8'h00 : add_c(st_q.msum, mdat_byte);
        end
        if (sbeat)
        begin
            st_d.scnt = sdat_last ? 4'h0 : st_q.scnt + 4'h1;
            st_d.ssum = sdat_last ? 8'h00 : add_c(st_q.ssum, sdat_byte);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_hdr_single_pulse: assert property (hdr_valid |=> !hdr_valid)
        else $error("header too long");
    a_pid_parity_bits: assert property (hdr_valid |-> hdr_pid[6] == (hdr_pid[0] ^ hdr_pid[1] ^ hdr_pid[2] ^ hdr_pid[4])
        && hdr_pid[7] == !(hdr_pid[1] ^ hdr_pid[3] ^ hdr_pid[4] ^ hdr_pid[5]))
        else $error("bad parity");
    a_one_talker: assert property (!(mdat_valid && sdat_valid))
        else $error("two talkers");
    a_answer_delay: assert property (sbeat && st_q.scnt == 4'h0 |-> $past(hdr_valid, 2))
        else $error("late answer");
    a_address_first: assert property (sbeat && st_q.scnt == 4'h0 |-> sdat_byte[7])
        else $error("no address");
    a_mdat_checksum: assert property (mbeat && mdat_last |-> mdat_byte == ~st_q.msum)
        else $error("bad write sum");
    a_sdat_checksum: assert property (sbeat && sdat_last |-> sdat_byte == ~st_q.ssum)
        else $error("bad answer sum");
    a_sdat_length: assert property (sbeat && sdat_last |-> st_q.scnt == st_q.len)
        else $error("answer length");
    a_mdat_length: assert property (mbeat && mdat_last |-> st_q.mcnt == st_q.len)
        else $error("write length");

    c_indirect_read: cover property (hdr_valid && hdr_pid == 8'h7D ##2 sdat_valid);
    c_long_write: cover property (mbeat && mdat_last && st_q.len == 4'h8);
    c_short_answer: cover property (sbeat && sdat_last && st_q.len == 4'h4);
endmodule
`default_nettype wire

/* bench/tb_lin_slave_read_and_dynamic_id.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_lin_slave_read_and_dynamic_id;
    import lsrd_pkg::*;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic        req_valid = 1'b0;
    logic [5:0]  req_id;
    logic [3:0]  req_len;
    logic [63:0] req_data;
    logic        req_read;
    logic        req_ready;
    logic        m_rsp_valid;
    logic [7:0]  m_rsp_byte;
    logic        m_rsp_last;
    logic        m_rsp_csum_ok;
    logic [6:0]  node_address = 7'h40;
    logic        read_cmd_valid;
    logic [6:0]  read_cmd;
    logic        app_valid = 1'b0;
    logic [7:0]  app_byte = 8'h00;
    logic        app_ready;
    logic        frame_error;
    logic        acc = 1'b0;
    logic        ok_due = 1'b0;
    logic [7:0]  sum = 8'h00;
    logic [7:0]  e;
    logic [6:0]  cmd;
    logic [6:0]  cq[$];
    logic [7:0]  bq[$];
    integer      seed = 85714;
    int          fail_count = 0;
    int          n_checks = 0;
    int          cyc = 0;

    always #20 clk_sys = ~clk_sys;

    lsrd_link_if i_lsrd_link_if();

    lsrd_master i_lsrd_master
    (
        .clk_sys     (clk_sys),
        .rst_n       (rst_n),
        .link        (i_lsrd_link_if),
        .req_valid   (req_valid),
        .req_id      (req_id),
        .req_len     (req_len),
        .req_data    (req_data),
        .req_read    (req_read),
        .req_ready   (req_ready),
        .rsp_valid   (m_rsp_valid),
        .rsp_byte    (m_rsp_byte),
        .rsp_last    (m_rsp_last),
        .rsp_csum_ok (m_rsp_csum_ok)
    );

    lsrd_slave i_lsrd_slave
    (
        .clk_sys        (clk_sys),
        .rst_n          (rst_n),
        .link           (i_lsrd_link_if),
        .node_address   (node_address),
        .read_cmd_valid (read_cmd_valid),
        .read_cmd       (read_cmd),
        .rsp_valid      (app_valid),
        .rsp_byte       (app_byte),
        .rsp_ready      (app_ready),
        .frame_error    (frame_error)
    );

    lsrd_link_assertions i_lsrd_link_assertions
    (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .hdr_valid  (i_lsrd_link_if.hdr_valid),
        .hdr_pid    (i_lsrd_link_if.hdr_pid),
        .mdat_valid (i_lsrd_link_if.mdat_valid),
        .mdat_ready (i_lsrd_link_if.mdat_ready),
        .mdat_byte  (i_lsrd_link_if.mdat_byte),
        .mdat_last  (i_lsrd_link_if.mdat_last),
        .sdat_valid (i_lsrd_link_if.sdat_valid),
        .sdat_ready (i_lsrd_link_if.sdat_ready),
        .sdat_byte  (i_lsrd_link_if.sdat_byte),
        .sdat_last  (i_lsrd_link_if.sdat_last)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] add_c(input logic [7:0] a, b);
        logic [8:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[7:0] + {7'h00, s[8]};
    endfunction

    function automatic logic [63:0] assign_frame(input logic brd, logic [6:0] ad,
        logic [5:0] i1, logic [3:0] p1, logic [5:0] i2, logic [3:0] p2,
        logic [5:0] i3, logic [3:0] p3, logic [5:0] i4, logic [3:0] p4);
        return {LSRD_APP_CMD_MARKER, 1'b1, LSRD_CMD_DYN_ASSIGN, brd, ad, i1[3:0], p1, i2[1:0], p2, i1[5:4],
                p3, i2[5:2], p4[1:0], i3, i4, p4[3:2]};
    endfunction

    function automatic logic [63:0] prep8(input logic [6:0] c, ad);
        return {LSRD_APP_CMD_MARKER, 1'b1, c, 1'b1, ad, {5{LSRD_FILLER_BYTE}}};
    endfunction

    task automatic check(input logic [7:0] got, exp);
        n_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic send(input logic [5:0] id, logic [3:0] len, logic [63:0] d, logic rd);
        while (req_ready !== 1'b1)
            @(negedge clk_sys);
        req_id = id;
        req_len = len;
        req_data = d;
        req_read = rd;
        req_valid = 1'b1;
        @(negedge clk_sys);
        req_valid = 1'b0;
        repeat (60) @(negedge clk_sys);
        $display("id=%h rd=%0b done", id, rd);
    endtask

    task automatic read_id(input logic [5:0] id, logic [3:0] len, logic ans, logic [6:0] c);
        if (ans)
            cq.push_back(c);
        send(id, len, 64'h0, 1'b1);
    endtask

    task automatic complete_run();
        $display("checks=%0d fails=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Answer source, random stalls
    // ------------------------------------------------------------
    always @(negedge clk_sys)
    begin
        if (!app_valid || acc)
        begin
            app_valid = 1'(($random(seed) & 3) != 0);
            app_byte = 8'($random(seed));
        end
    end

    // ------------------------------------------------------------
    // Monitor
    // ------------------------------------------------------------
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            fail_count++;
            complete_run();
        end
        if (ok_due)
            check({7'h00, m_rsp_csum_ok}, 8'h01);
        ok_due = 1'b0;
        if (read_cmd_valid)
        begin
            check({1'b0, read_cmd}, cq.size() != 0 ? {1'b0, cq.pop_front()} : {1'b1, read_cmd});
            bq.push_back({1'b1, node_address});
        end
        if (app_valid && app_ready)
            bq.push_back(app_byte);
        acc = app_valid && app_ready;
        if (m_rsp_valid && !m_rsp_last)
        begin
            e = bq.size() != 0 ? bq.pop_front() : ~m_rsp_byte;
            check(m_rsp_byte, e);
            sum = add_c(sum, e);
        end
        if (m_rsp_valid && m_rsp_last)
        begin
            check(m_rsp_byte, ~sum);
            sum = 8'h00;
            ok_due = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        node_address = 7'($random(seed)) | 7'h40;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        rst_n = 1'b1;
        send(6'h3C, 4'h8, assign_frame(1'b0, 7'h00, 6'h1A, 4'h8, 6'h25, 4'h2, 6'h31, 4'h3, 6'h05, 4'h4), 1'b0);
        read_id(6'h25, 4'h4, 1'b1, 7'h02);
        read_id(6'h31, 4'h8, 1'b1, 7'h03);
        read_id(6'h05, 4'h2, 1'b1, 7'h04);
        read_id(6'h3D, 4'h8, 1'b0, 7'h00);
        cmd = 7'($random(seed)) | 7'h20;
        send(6'h3C, 4'h8, prep8(cmd, node_address), 1'b0);
        read_id(6'h3D, 4'h8, 1'b1, cmd);
        send(6'h1A, 4'h2, {1'b1, ~cmd, 1'b1, node_address, 48'h0}, 1'b0);
        read_id(6'h3D, 4'h8, 1'b1, ~cmd);
        send(6'h3C, 4'h8, prep8(cmd, node_address ^ 7'h01), 1'b0);
        read_id(6'h3D, 4'h8, 1'b0, 7'h00);
        send(6'h3C, 4'h8, prep8(cmd, node_address) ^ {8'h01, 56'h0}, 1'b0);
        read_id(6'h3D, 4'h8, 1'b0, 7'h00);
        send(6'h3C, 4'h8, prep8(cmd, node_address), 1'b0);
        read_id(6'h25, 4'h4, 1'b1, 7'h02);
        read_id(6'h3D, 4'h8, 1'b0, 7'h00);
        send(6'h3C, 4'h8, assign_frame(1'b1, node_address ^ 7'h01, 6'h26, 4'h5, 6'h26, 4'h5, 6'h26, 4'h5,
             6'h26, 4'h5), 1'b0);
        read_id(6'h26, 4'h4, 1'b0, 7'h00);
        send(6'h3C, 4'h8, assign_frame(1'b1, node_address, 6'h26, 4'h5, 6'h1A, 4'h8, 6'h25, 4'h2,
             6'h31, 4'h3), 1'b0);
        read_id(6'h26, 4'h4, 1'b1, 7'h05);
        check({7'h00, frame_error}, 8'h00);
        check(8'(bq.size() + cq.size()), 8'h00);
        complete_run();
    end
endmodule
`default_nettype wire

/* src/lsrd_link_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface lsrd_link_if;
    import lsrd_pkg::*;
    // Header: master announces protected identifier
    logic       hdr_valid;
    logic [7:0] hdr_pid;
    // Master data bytes
    logic       mdat_valid;
    logic       mdat_ready;
    logic [7:0] mdat_byte;
    logic       mdat_last;
    // Slave response bytes
    logic       sdat_valid;
    logic       sdat_ready;
    logic [7:0] sdat_byte;
    logic       sdat_last;

    modport master
    (
        output hdr_valid, hdr_pid, mdat_valid, mdat_byte, mdat_last, sdat_ready,
        input  mdat_ready, sdat_valid, sdat_byte, sdat_last
    );
    modport slave
    (
        input  hdr_valid, hdr_pid, mdat_valid, mdat_byte, mdat_last, sdat_ready,
        output mdat_ready, sdat_valid, sdat_byte, sdat_last
    );
endinterface
`default_nettype wire

/* src/lsrd_master.sv */
`timescale 1ns/1ns
`default_nettype none
module lsrd_master
    import lsrd_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    lsrd_link_if.master     link,
    input  wire logic       req_valid,
    input  wire logic [5:0] req_id,
    input  wire logic [3:0] req_len,
    input  wire logic [63:0] req_data,
    input  wire logic       req_read,
    output logic            req_ready,
    output logic            rsp_valid,
    output logic [7:0]      rsp_byte,
    output logic            rsp_last,
    output logic            rsp_csum_ok
);

    typedef enum logic [1:0]
    {
        M_IDLE  = 2'b00,
        M_WRITE = 2'b01,
        M_READ  = 2'b10
    } lsrd_mst_type;

    typedef struct packed
    {
        lsrd_mst_type st;
        logic         hdr_v;
        logic [7:0]   pid;
        logic         md_v;
        logic [7:0]   md_b;
        logic         md_l;
        logic [63:0]  data;
        logic [3:0]   len;
        logic [3:0]   idx;
        logic [7:0]   acc;
        logic         rdy;
        logic         rv;
        logic [7:0]   rb;
        logic         rl;
        logic         rok;
    } lsrd_mst_state_type;

    lsrd_mst_state_type s_q;
    lsrd_mst_state_type s_d;

    always_comb
    begin
        s_d = s_q;
        s_d.hdr_v = 1'b0;
        s_d.rv = 1'b0;
        s_d.rdy = 1'b0;
        unique case (s_q.st)
            M_IDLE:
            begin
                s_d.rdy = 1'b1;
                if (req_valid && s_q.rdy)
                begin
                    s_d.hdr_v = 1'b1;
                    s_d.pid = lsrd_protect(req_id);
                    s_d.len = req_len;
                    s_d.data = req_data;
                    s_d.idx = 4'h0;
                    s_d.acc = 8'h00;
                    s_d.rdy = 1'b0;
                    s_d.st = req_read ? M_READ : M_WRITE;
                end
            end
            M_WRITE:
            begin
                if (!s_q.md_v || link.mdat_ready)
                begin
                    if (s_q.idx <= s_q.len && !(s_q.md_v && s_q.md_l))
                    begin
                        s_d.md_v = 1'b1;
                        if (s_q.idx == s_q.len)
                        begin
                            s_d.md_b = ~s_q.acc;
                            s_d.md_l = 1'b1;
                        end
                        else
                        begin
                            s_d.md_b = s_q.data[8 * (7 - s_q.idx[2:0]) +: 8];
                            s_d.md_l = 1'b0;
                            s_d.acc = lsrd_csum_add(s_q.acc, s_d.md_b);
                        end
                        s_d.idx = s_q.idx + 4'h1;
                    end
                    else
                    begin
                        s_d.md_v = 1'b0;
                        s_d.md_l = 1'b0;
                        s_d.st = M_IDLE;
                    end
                end
            end
            M_READ:
            begin
                if (link.sdat_valid)
                begin
                    s_d.idx = 4'h0;
                    s_d.rv = 1'b1;
                    s_d.rb = link.sdat_byte;
                    s_d.rl = link.sdat_last;
                    if (link.sdat_last)
                    begin
                        s_d.rok = (link.sdat_byte == ~s_q.acc);
                        s_d.st = M_IDLE;
                    end
                    else
                    begin
                        s_d.acc = lsrd_csum_add(s_q.acc, link.sdat_byte);
                    end
                end
                else if (s_q.idx == LSRD_RSP_WAIT)
                begin
                    s_d.st = M_IDLE; // No answer: frame given up
                end
                else
                begin
                    s_d.idx = s_q.idx + 4'h1;
                end
            end
            default:
            begin
                s_d.st = M_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign link.hdr_valid  = s_q.hdr_v;
    assign link.hdr_pid    = s_q.pid;
    assign link.mdat_valid = s_q.md_v;
    assign link.mdat_byte  = s_q.md_b;
    assign link.mdat_last  = s_q.md_l;
    assign link.sdat_ready = 1'b1;
    assign req_ready       = s_q.rdy;
    assign rsp_valid       = s_q.rv;
    assign rsp_byte        = s_q.rb;
    assign rsp_last        = s_q.rl;
    assign rsp_csum_ok     = s_q.rok;

endmodule
`default_nettype wire

/* src/lsrd_pkg.sv */
package lsrd_pkg;

    // ------------------------------------------------------------
    // Identifiers and frame codes
    // ------------------------------------------------------------
    localparam logic [5:0] LSRD_ID_CMD_FRAME     = 6'h3C;
    localparam logic [5:0] LSRD_ID_INDIRECT_READ = 6'h3D;
    localparam logic [5:0] LSRD_ID_EXTENDED      = 6'h3F;
    localparam logic [7:0] LSRD_APP_CMD_MARKER   = 8'h80;
    localparam logic [6:0] LSRD_CMD_DYN_ASSIGN   = 7'h11;
    localparam logic [7:0] LSRD_FILLER_BYTE      = 8'hFF;
    localparam logic [3:0] LSRD_PTR_PREPARE      = 4'h8;
    localparam int         LSRD_SLOTS            = 16;
    localparam int         LSRD_PAIRS            = 4;
    localparam logic [3:0] LSRD_PREP8_LEN        = 4'h8;
    localparam logic [3:0] LSRD_RSP_WAIT         = 4'hF;
    localparam logic [5:0] LSRD_ID_RESET         = 6'h3F;

    // ------------------------------------------------------------
    // Shared functions
    // ------------------------------------------------------------
    function automatic logic [7:0] lsrd_protect(input logic [5:0] id);
        logic p0;
        logic p1;
        p0 = id[0] ^ id[1] ^ id[2] ^ id[4];
        p1 = ~(id[1] ^ id[3] ^ id[4] ^ id[5]);
        return {p1, p0, id};
    endfunction

    function automatic logic [3:0] lsrd_length(input logic [5:0] id);
        unique case (id[5:4])
            2'b10:   return 4'h4;
            2'b11:   return 4'h8;
            default: return 4'h2;
        endcase
    endfunction

    function automatic logic [7:0] lsrd_csum_add(input logic [7:0] acc, input logic [7:0] b);
        logic [8:0] s;
        s = {1'b0, acc} + {1'b0, b};
        return s[7:0] + {7'h00, s[8]};
    endfunction

endpackage

/* src/lsrd_slave.sv */
// Notes on behaviour
// - One slave answers each read
// - Direct identifier only reads
// - Indirect read needs preparing first
// - Answers carry own node address
// - Direct read needs no preparing
// - 0x3D is eight-byte indirect read
// - Preparing names node and command
// - Two-byte preparing uses pointer eight
// - Eight-byte preparing uses 0x3C
// - Marker 0x80 enables command decode
// - 0x3C, 0x3F never assigned
// - Command 0x11 assigns identifiers
// - Four pairs per assignment frame
// - Fixed packing of bytes four to eight
// - Broadcast bit zero: all slaves store
// - Up to three assignment frames; the slave does not count them and accepts any number
// - Inverted carry sum over data
// - Identifier parity in bits 6, 7
// - Identifier bits 5, 4 give length
`timescale 1ns/1ns
`default_nettype none
module lsrd_slave
    import lsrd_pkg::*;
#(
    parameter int SLOTS = LSRD_SLOTS
)
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    lsrd_link_if.slave       link,
    input  wire logic [6:0]  node_address,
    output logic             read_cmd_valid,
    output logic [6:0]       read_cmd,
    input  wire logic        rsp_valid,
    input  wire logic [7:0]  rsp_byte,
    output logic             rsp_ready,
    output logic             frame_error
);

    typedef enum logic [2:0]
    {
        S_IDLE  = 3'b000,
        S_RECV  = 3'b001,
        S_RESP  = 3'b010,
        S_CSUM  = 3'b011,
        S_DONE  = 3'b100
    } lsrd_slv_type;

    typedef struct packed
    {
        lsrd_slv_type st;
        logic [5:0]   id;
        logic [3:0]   len;
        logic [3:0]   idx;
        logic [7:0]   acc;
        logic [63:0]  rx;
        logic         pend;
        logic [6:0]   pend_cmd;
        logic         rc_v;
        logic [6:0]   rc;
        logic         err;
        logic [1:0]   bcnt;
        logic [15:0]  bdat;
    } lsrd_slv_state_type;

    lsrd_slv_state_type s_q;
    lsrd_slv_state_type s_d;
    logic [5:0]         slot_id_q [SLOTS];
    logic               slot_we;
    logic [5:0]         wr_id [LSRD_PAIRS];
    logic [3:0]         wr_ptr [LSRD_PAIRS];

    function automatic logic [3:0] slot_of(input logic [5:0] id, input logic [5:0] tbl [SLOTS]);
        logic [3:0] hit;
        hit = 4'hF;
        for (int i = 0; i < SLOTS; i++)
        begin
            if (tbl[i] == id)
            begin
                hit = 4'(i);
            end
        end
        return hit;
    endfunction

    // ------------------------------------------------------------
    // Assignment frame unpacking
    // ------------------------------------------------------------
    always_comb
    begin
        wr_ptr[0] = s_q.rx[35:32];
        wr_id[0]  = {s_q.rx[25:24], s_q.rx[39:36]};
        wr_ptr[1] = s_q.rx[29:26];
        wr_id[1]  = {s_q.rx[19:16], s_q.rx[31:30]};
        wr_ptr[2] = s_q.rx[23:20];
        wr_id[2]  = s_q.rx[13:8];
        wr_ptr[3] = {s_q.rx[1:0], s_q.rx[15:14]};
        wr_id[3]  = s_q.rx[7:2];
    end

    // ------------------------------------------------------------
    // Frame handling
    // ------------------------------------------------------------
    logic [3:0] hit;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] b3;
    logic       is_cmd;

    always_comb
    begin
        s_d = s_q;
        slot_we = 1'b0;
        s_d.rc_v = 1'b0;
        hit = slot_of(link.hdr_pid[5:0], slot_id_q);
        b1 = s_q.rx[63:56];
        b2 = s_q.rx[55:48];
        b3 = s_q.rx[47:40];
        is_cmd = (s_q.id == LSRD_ID_CMD_FRAME) && (b1 == LSRD_APP_CMD_MARKER);
        if (link.hdr_valid)
        begin
            s_d.id = link.hdr_pid[5:0];
            s_d.len = lsrd_length(link.hdr_pid[5:0]);
            s_d.idx = 4'h0;
            s_d.acc = 8'h00;
            s_d.rx = '0;
            s_d.pend = 1'b0;
            s_d.bcnt = 2'd0;
            s_d.st = S_IDLE;
            if (link.hdr_pid != lsrd_protect(link.hdr_pid[5:0]))
            begin
                s_d.err = 1'b1;
            end
            else if (link.hdr_pid[5:0] == LSRD_ID_INDIRECT_READ)
            begin
                if (s_q.pend)
                begin
                    s_d.len = LSRD_PREP8_LEN;
                    s_d.rc_v = 1'b1;
                    s_d.rc = s_q.pend_cmd;
                    s_d.st = S_RESP;
                end
            end
            else if (hit != 4'hF && hit != LSRD_PTR_PREPARE
                     && link.hdr_pid[5:0] != LSRD_ID_CMD_FRAME && link.hdr_pid[5:0] != LSRD_ID_EXTENDED)
            begin
                // Direct read: slot index is the command
                s_d.rc_v = 1'b1;
                s_d.rc = {3'b000, hit};
                s_d.st = S_RESP;
            end
            else
            begin
                s_d.st = S_RECV;
            end
        end
        else
        begin
            unique case (s_q.st)
                S_RECV:
                begin
                    if (link.mdat_valid)
                    begin
                        if (s_q.idx == s_q.len)
                        begin
                            s_d.st = S_DONE;
                            if (link.mdat_byte != ~s_q.acc)
                            begin
                                s_d.err = 1'b1;
                                s_d.st = S_IDLE;
                            end
                        end
                        else
                        begin
                            s_d.rx[8 * (7 - s_q.idx[2:0]) +: 8] = link.mdat_byte;
                            s_d.acc = lsrd_csum_add(s_q.acc, link.mdat_byte);
                            s_d.idx = s_q.idx + 4'h1;
                        end
                    end
                end
                S_DONE:
                begin
                    s_d.st = S_IDLE;
                    if (slot_of(s_q.id, slot_id_q) == LSRD_PTR_PREPARE && !s_q.id[5]
                        && b1[7] && b2[7] && b2[6:0] == node_address)
                    begin
                        s_d.pend = 1'b1;
                        s_d.pend_cmd = b1[6:0];
                    end
                    else if (is_cmd && b2[6:0] == LSRD_CMD_DYN_ASSIGN)
                    begin
                        if (!b3[7] || b3[6:0] == node_address)
                        begin
                            slot_we = 1'b1;
                        end
                    end
                    else if (is_cmd && b2[7] && b3[7] && b3[6:0] == node_address
                             && s_q.rx[39:0] == {5{LSRD_FILLER_BYTE}})
                    begin
                        s_d.pend = 1'b1;
                        s_d.pend_cmd = b2[6:0];
                    end
                end
                S_RESP:
                begin
                    // Two-entry buffer, own address first
                    if (s_q.bcnt < 2'd2)
                    begin
                        if (s_q.idx == 4'h0)
                        begin
                            s_d.bdat = {s_q.bdat[7:0], 1'b1, node_address};
                            s_d.bcnt = s_q.bcnt + 2'd1;
                            s_d.idx = 4'h1;
                            s_d.acc = lsrd_csum_add(s_q.acc, {1'b1, node_address});
                        end
                        else if (rsp_valid && s_q.idx < s_q.len)
                        begin
                            s_d.bdat = {s_q.bdat[7:0], rsp_byte};
                            s_d.bcnt = s_q.bcnt + 2'd1;
                            s_d.idx = s_q.idx + 4'h1;
                            s_d.acc = lsrd_csum_add(s_q.acc, rsp_byte);
                        end
                        else if (s_q.idx == s_q.len)
                        begin
                            s_d.bdat = {s_q.bdat[7:0], ~s_q.acc};
                            s_d.bcnt = s_q.bcnt + 2'd1;
                            s_d.idx = s_q.idx + 4'h1;
                        end
                    end
                    if (s_q.bcnt != 2'd0 && link.sdat_ready)
                    begin
                        s_d.bcnt = s_d.bcnt - 2'd1;
                        if (s_q.bcnt == 2'd1 && s_q.idx > s_q.len)
                        begin
                            s_d.st = S_CSUM;
                        end
                    end
                end
                S_CSUM:
                begin
                    s_d.st = S_IDLE;
                end
                default:
                begin
                    s_d.st = S_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Identifier table
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < SLOTS; i++)
            begin
                slot_id_q[i] <= LSRD_ID_RESET;
            end
        end
        else if (slot_we)
        begin
            for (int p = 0; p < LSRD_PAIRS; p++)
            begin
                if (wr_id[p] != LSRD_ID_CMD_FRAME && wr_id[p] != LSRD_ID_EXTENDED)
                begin
                    slot_id_q[wr_ptr[p]] <= wr_id[p];
                end
            end
        end
    end

    assign link.mdat_ready = 1'b1;
    assign link.sdat_valid = (s_q.st == S_RESP) && (s_q.bcnt != 2'd0);
    assign link.sdat_byte  = (s_q.bcnt == 2'd2) ? s_q.bdat[15:8] : s_q.bdat[7:0];
    assign link.sdat_last  = link.sdat_valid && (s_q.bcnt == 2'd1) && (s_q.idx > s_q.len);
    assign read_cmd_valid  = s_q.rc_v;
    assign read_cmd        = s_q.rc;
    assign rsp_ready       = (s_q.st == S_RESP) && (s_q.bcnt < 2'd2) && (s_q.idx != 4'h0) && (s_q.idx < s_q.len);
    assign frame_error     = s_q.err;

endmodule
`default_nettype wire
